// [rtl/drf_core.sv]
// Dark row and column readout framing plus flash strobe control
// Assumes a timing generator on sys_clk and a simple register port
`timescale 1ns/1ns
`default_nettype none
`include "drf_regs.svh"
// Behaviour
// - With dark rows enabled, read count-field-plus-one dark rows at each frame start
// - Dark-row control bit 3 is stored and read back, with no effect
// - Show bit outputs dark rows plus two rows before and after; frame strobe earlier
// - Showing dark and extra rows leaves integration and frame rate alone
// - Dark-column enable reads dark columns 2..21 for row noise correction
// - Dark-column readout raises minimum horizontal blanking, row time unchanged
// - Show-columns outputs 20 dark columns, then two idle pixels, then active
// - Shown dark columns move line strobe 22 pixels early, blanking 22 shorter
// - LED mode: strobe before frame reset begins, held until readout ends
// - Every-frame bit: 1 fires each frame, 0 fires one frame only
// - Xenon: end-of-reset bit picks trigger after reset or after readout
// - Flash pulse delayed by the two-bit frame-delay count
// - Xenon mode: strobe during vertical blanking for the pulse-length count
// - Xenon keeps integration at one frame; pulse shorter than vertical blanking
// - Read-only bit 14 shows the strobe fired in the current frame
// - Read-only bit 15 shows the live strobe level
module drf_core (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Frame timing
  input wire logic frame_start,
  input wire logic row_start,
  input wire logic active_row,
  input wire logic dark_row_enable,
  input wire logic reset_soon,
  input wire logic reset_done,
  input wire logic readout_done,
  input wire logic vblank,
  // Pixel stream in
  input wire logic pix_tick,
  input wire logic line_active,
  input wire logic [9:0] pix_data,
  output logic pix_ready,
  // Pixel stream out
  output logic frame_valid,
  output logic line_valid,
  output logic out_valid,
  input wire logic out_ready,
  output logic [9:0] out_data,
  // Readout controls
  output logic dark_row_rd,
  output logic [2:0] dark_row_addr,
  output logic dark_col_rd,
  output logic [5:0] hblank_min_add,
  output logic [5:0] hblank_cut,
  output logic one_frame_int,
  // Strobe pin
  output logic lamp_strobe
);
  import drf_pkg::*;

  function automatic logic in_rng(input logic [11:0] c, input logic [11:0] lo,
                                  input logic [11:0] hi);
    in_rng = (c >= lo) && (c < hi);
  endfunction

  // ************************************************************
  // Registers
  // ************************************************************
  logic [15:0] drc, next_drc, sc, next_sc, next_rdata;
  logic lamp_strobe_enable, next_lamp_en, xe_en, next_xe_en;
  logic trig, next_trig;

  always_comb begin
    next_drc = drc;
    next_sc = sc;
    next_lamp_en = lamp_strobe_enable;
    next_xe_en = xe_en;
    next_rdata = reg_rdata;
    if (reg_wr) begin
      if (reg_addr == `DRF_ADDR_DRC) begin
        next_drc = reg_wdata & `DRF_DRC_MASK;
      end else if (reg_addr == `DRF_ADDR_SC) begin
        next_sc = reg_wdata & `DRF_SC_MASK;
      end
    end
    if (frame_start) begin
      next_lamp_en = sc[`DRF_SC_LAMP];
      next_xe_en = sc[`DRF_SC_XENON];
    end
    if (reg_rd) begin
      if (reg_addr == `DRF_ADDR_DRC) begin
        next_rdata = drc;
      end else if (reg_addr == `DRF_ADDR_SC) begin
        next_rdata = sc;
        next_rdata[`DRF_SC_TRIG] = trig;
        next_rdata[`DRF_SC_LIVE] = lamp_strobe;
      end else begin
        next_rdata = 16'h0000;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      drc <= `DRF_DRC_RESET;
      sc <= `DRF_SC_RESET;
      lamp_strobe_enable <= 1'b0;
      xe_en <= 1'b0;
      reg_rdata <= 16'h0000;
    end else begin
      drc <= next_drc;
      sc <= next_sc;
      lamp_strobe_enable <= next_lamp_en;
      xe_en <= next_xe_en;
      reg_rdata <= next_rdata;
    end
  end

  logic show_rows, read_cols, show_cols;
  assign show_rows = drc[`DRF_DRC_SHOW_ROWS];
  assign read_cols = drc[`DRF_DRC_READ_COLS];
  assign show_cols = drc[`DRF_DRC_SHOW_COLS] && read_cols;

  // ************************************************************
  // Row sequencer
  // ************************************************************
  drf_row_state_t rstate, next_rstate;
  logic [2:0] row_cnt, next_row_cnt, next_daddr;
  logic act_seen, next_act_seen, next_fv, next_drd;

  always_comb begin
    next_rstate = rstate;
    next_row_cnt = row_cnt;
    next_daddr = dark_row_addr;
    next_act_seen = act_seen;
    if (frame_start) begin
      next_row_cnt = 3'h0;
      next_act_seen = 1'b0;
      next_daddr = drc[`DRF_DRC_DSTART];
      if (dark_row_enable) begin
        next_rstate = DRF_R_DARK;
      end else if (show_rows) begin
        next_rstate = DRF_R_PRE;
      end else begin
        next_rstate = DRF_R_ACT;
      end
    end else if (row_start) begin
      if (active_row) begin
        next_act_seen = 1'b1;
      end
      case (rstate)
        DRF_R_DARK: begin
          if (row_cnt == drc[`DRF_DRC_NDARK]) begin
            next_row_cnt = 3'h0;
            next_rstate = show_rows ? DRF_R_PRE : DRF_R_ACT;
          end else begin
            next_row_cnt = row_cnt + 3'h1;
            next_daddr = dark_row_addr + 3'h1;
          end
        end
        DRF_R_PRE: begin
          if (row_cnt == `DRF_EXTRA_LAST) begin
            next_row_cnt = 3'h0;
            next_rstate = DRF_R_ACT;
          end else begin
            next_row_cnt = row_cnt + 3'h1;
          end
        end
        DRF_R_ACT: begin
          if (act_seen && !active_row) begin
            next_rstate = show_rows ? DRF_R_POST : DRF_R_IDLE;
          end
        end
        DRF_R_POST: begin
          if (row_cnt == `DRF_EXTRA_LAST) begin
            next_rstate = DRF_R_IDLE;
          end else begin
            next_row_cnt = row_cnt + 3'h1;
          end
        end
        default: begin
          next_rstate = DRF_R_IDLE;
        end
      endcase
    end
    // Rows only leave blanking; frame_start spacing is untouched
    if (show_rows) begin
      next_fv = next_rstate != DRF_R_IDLE;
    end else begin
      next_fv = (next_rstate == DRF_R_ACT) && active_row;
    end
    next_drd = next_rstate == DRF_R_DARK;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rstate <= DRF_R_IDLE;
      row_cnt <= 3'h0;
      dark_row_addr <= 3'h0;
      act_seen <= 1'b0;
      frame_valid <= 1'b0;
      dark_row_rd <= 1'b0;
    end else begin
      rstate <= next_rstate;
      row_cnt <= next_row_cnt;
      dark_row_addr <= next_daddr;
      act_seen <= next_act_seen;
      frame_valid <= next_fv;
      dark_row_rd <= next_drd;
    end
  end

  // ************************************************************
  // Column framing and pixel push
  // ************************************************************
  logic [11:0] col, next_col;
  logic next_lv, next_dcr, push;
  logic [9:0] push_data;
  logic [5:0] next_hmin, next_hcut;

  always_comb begin
    next_col = col;
    if (row_start) begin
      next_col = 12'h000;
    end else if (pix_tick && col != `DRF_COL_MAX) begin
      next_col = col + 12'h001;
    end
    next_lv = line_valid && next_fv;
    if (pix_tick) begin
      next_lv = next_fv && (line_active || (show_cols
                && in_rng(col, `DRF_COL_DARK_FIRST, `DRF_COL_ACT_FIRST)));
    end
    next_dcr = read_cols && in_rng(col, `DRF_COL_DARK_FIRST, `DRF_COL_GAP_FIRST);
    push = pix_tick && next_lv;
    push_data = pix_data;
    if (show_cols && in_rng(col, `DRF_COL_GAP_FIRST, `DRF_COL_ACT_FIRST)) begin
      push_data = `DRF_IDLE_PIXEL;
    end
    next_hmin = read_cols ? `DRF_HB_DARK_ADD : 6'h00;
    next_hcut = show_cols ? `DRF_HB_SHOW_CUT : 6'h00;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      col <= 12'h000;
      line_valid <= 1'b0;
      dark_col_rd <= 1'b0;
      hblank_min_add <= 6'h00;
      hblank_cut <= 6'h00;
    end else begin
      col <= next_col;
      line_valid <= next_lv;
      dark_col_rd <= next_dcr;
      hblank_min_add <= next_hmin;
      hblank_cut <= next_hcut;
    end
  end

  drf_fifo #(.W(10), .D(32)) u_fifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .in_valid(push),
    .in_ready(pix_ready),
    .in_data(push_data),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_data)
  );

  // ************************************************************
  // Flash strobe
  // ************************************************************
  drf_flash_state_t fstate, next_fstate;
  logic armed, next_armed, fire, next_fire, next_strobe, next_ofi, any_en, xe_trig;
  logic [1:0] dly, next_dly;
  logic [7:0] xe_left, next_xe_left;

  always_comb begin
    next_fstate = fstate;
    next_armed = armed;
    next_fire = fire;
    next_dly = dly;
    next_xe_left = xe_left;
    any_en = sc[`DRF_SC_LAMP] || sc[`DRF_SC_XENON];
    xe_trig = sc[`DRF_SC_EOR] ? reset_done : readout_done;
    if (frame_start) begin
      next_fire = 1'b0;
      if (any_en && !(lamp_strobe_enable || xe_en)) begin
        next_armed = 1'b1;
        next_dly = sc[`DRF_SC_DELAY];
      end
      if (any_en && (next_armed || armed)) begin
        if (next_dly == 2'h0) begin
          next_fire = 1'b1;
          next_armed = sc[`DRF_SC_EVERY];
        end else begin
          next_dly = next_dly - 2'h1;
        end
      end
    end
    case (fstate)
      DRF_F_OFF: begin
        if (fire && lamp_strobe_enable && reset_soon) begin
          next_fstate = DRF_F_LED;
          next_fire = 1'b0;
        end else if (fire && xe_en && xe_trig) begin
          next_fire = 1'b0;
          next_xe_left = sc[`DRF_SC_COUNT];
          if (sc[`DRF_SC_COUNT] != 8'h00) begin
            next_fstate = DRF_F_XWAIT;
          end
        end
      end
      DRF_F_LED: begin
        if (readout_done) begin
          next_fstate = DRF_F_OFF;
        end
      end
      DRF_F_XWAIT: begin
        if (vblank) begin
          next_fstate = DRF_F_XPULSE;
        end
      end
      DRF_F_XPULSE: begin
        if (!vblank) begin
          next_fstate = DRF_F_OFF;
        end else if (row_start) begin
          next_xe_left = xe_left - 8'h01;
          if (xe_left == 8'h01) begin
            next_fstate = DRF_F_OFF;
          end
        end
      end
      default: begin
        next_fstate = DRF_F_OFF;
      end
    endcase
    next_strobe = (next_fstate == DRF_F_LED) || (next_fstate == DRF_F_XPULSE);
    next_trig = (trig && !frame_start) || next_strobe;
    next_ofi = xe_en;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      fstate <= DRF_F_OFF;
      armed <= 1'b0;
      fire <= 1'b0;
      dly <= 2'h0;
      xe_left <= 8'h00;
      trig <= 1'b0;
      lamp_strobe <= 1'b0;
      one_frame_int <= 1'b0;
    end else begin
      fstate <= next_fstate;
      armed <= next_armed;
      fire <= next_fire;
      dly <= next_dly;
      xe_left <= next_xe_left;
      trig <= next_trig;
      lamp_strobe <= next_strobe;
      one_frame_int <= next_ofi;
    end
  end
endmodule
`default_nettype wire

// [rtl/drf_fifo.sv]
// Pixel FIFO with valid and ready on both sides
// Assumes D is a power of two; output data come from a register
`timescale 1ns/1ns
`default_nettype none
module drf_fifo #(
  parameter int W = 10,
  parameter int D = 32
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [AW-1:0] wp, rp, next_wp, next_rp;
  logic [AW:0] cnt, next_cnt;
  logic next_ov, next_rdy, wr_en, rd_en;
  assign wr_en = in_valid && in_ready;
  assign rd_en = (cnt != '0) && (!out_valid || out_ready);
  always_comb begin
    next_wp = wr_en ? wp + AW'(1) : wp;
    next_rp = rd_en ? rp + AW'(1) : rp;
    next_cnt = cnt;
    if (wr_en && !rd_en) begin
      next_cnt = cnt + (AW+1)'(1);
    end else if (rd_en && !wr_en) begin
      next_cnt = cnt - (AW+1)'(1);
    end
    next_ov = rd_en ? 1'b1 : (out_ready ? 1'b0 : out_valid);
    next_rdy = next_cnt != (AW+1)'(D);
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
      out_valid <= 1'b0;
      in_ready <= 1'b1;
    end else begin
      wp <= next_wp;
      rp <= next_rp;
      cnt <= next_cnt;
      out_valid <= next_ov;
      in_ready <= next_rdy;
    end
  end
  drf_mem #(.W(W), .D(D), .AW(AW)) u_mem (
    .sys_clk(sys_clk),
    .wr_en(wr_en),
    .wr_addr(wp),
    .wr_data(in_data),
    .rd_en(rd_en),
    .rd_addr(rp),
    .rd_data(out_data)
  );
endmodule
`default_nettype wire

// [rtl/drf_mem.sv]
// Small memory with registered read data
// Assumes one write and one read port on sys_clk
`timescale 1ns/1ns
`default_nettype none
module drf_mem #(
  parameter int W = 10,
  parameter int D = 32,
  parameter int AW = 5
) (
  // Clock
  input wire logic sys_clk,
  // Write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [W-1:0] wr_data,
  // Read port
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [W-1:0] rd_data
);
  logic [W-1:0] mem [D];
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule
`default_nettype wire

// [rtl/drf_pkg.sv]
// Types shared by the readout and strobe control block
// Offsets and counts live in drf_regs.svh
package drf_pkg;
  typedef enum logic [4:0] {
    DRF_R_IDLE = 5'b00001,
    DRF_R_DARK = 5'b00010,
    DRF_R_PRE = 5'b00100,
    DRF_R_ACT = 5'b01000,
    DRF_R_POST = 5'b10000
  } drf_row_state_t;
  typedef enum logic [3:0] {
    DRF_F_OFF = 4'b0001,
    DRF_F_LED = 4'b0010,
    DRF_F_XWAIT = 4'b0100,
    DRF_F_XPULSE = 4'b1000
  } drf_flash_state_t;
endpackage

// [rtl/drf_regs.svh]
// Register offsets, field positions, reset values and counts
// Included by the core; definitions only
`ifndef DRF_REGS_SVH
`define DRF_REGS_SVH
`define DRF_ADDR_DRC 8'h22
`define DRF_ADDR_SC 8'h23
`define DRF_DRC_RESET 16'h000F
`define DRF_DRC_MASK 16'h03FF
`define DRF_DRC_NDARK 2:0
`define DRF_DRC_SPARE 3
`define DRF_DRC_DSTART 6:4
`define DRF_DRC_SHOW_ROWS 7
`define DRF_DRC_READ_COLS 8
`define DRF_DRC_SHOW_COLS 9
`define DRF_SC_RESET 16'h0200
`define DRF_SC_MASK 16'h3FFF
`define DRF_SC_COUNT 7:0
`define DRF_SC_LAMP 8
`define DRF_SC_EVERY 9
`define DRF_SC_EOR 10
`define DRF_SC_DELAY 12:11
`define DRF_SC_XENON 13
`define DRF_SC_TRIG 14
`define DRF_SC_LIVE 15
`define DRF_EXTRA_LAST 3'h1
`define DRF_COL_DARK_FIRST 12'h002
`define DRF_COL_GAP_FIRST 12'h016
`define DRF_COL_ACT_FIRST 12'h018
`define DRF_COL_MAX 12'hFFF
`define DRF_HB_SHOW_CUT 6'h16
`define DRF_HB_DARK_ADD 6'h16
`define DRF_IDLE_PIXEL 10'h000
`endif

// [tb/drf_core_sva.sv]
// Port assertions for the readout framing and strobe block
// Bound to drf_core; sees only its ports, one clock domain
`timescale 1ns/1ns
`default_nettype none
module drf_core_sva (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // Timing inputs
  input wire logic frame_start,
  input wire logic row_start,
  input wire logic dark_row_enable,
  input wire logic reset_soon,
  input wire logic readout_done,
  input wire logic vblank,
  input wire logic pix_tick,
  // Outputs
  input wire logic frame_valid,
  input wire logic line_valid,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic [9:0] out_data,
  input wire logic dark_row_rd,
  input wire logic [5:0] hblank_min_add,
  input wire logic [5:0] hblank_cut,
  input wire logic one_frame_int,
  input wire logic lamp_strobe
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // ****************
  // Port relations
  // ****************
  unmapped_read_a: assert property (reg_rd && reg_addr != 8'h22 && reg_addr != 8'h23
    |=> reg_rdata == 16'h0000) else $error("unmapped read not zero");
  rdata_hold_a: assert property (!reg_rd && !$past(reg_rd) |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  hb_cut_a: assert property (hblank_cut != 6'h00 |-> hblank_cut == 6'h16
    && hblank_min_add == 6'h16) else $error("blanking cut wrong");
  hb_add_a: assert property (hblank_min_add inside {6'h00, 6'h16})
    else $error("blanking add wrong");
  strobe_rise_a: assert property ($rose(lamp_strobe) |-> $past(reset_soon)
    || $past(reset_soon, 2) || $past(vblank)) else $error("strobe rose without cause");
  strobe_fall_a: assert property ($fell(lamp_strobe) |-> $past(readout_done)
    || $past(readout_done, 2) || $past(row_start) || $past(row_start, 2) || !$past(vblank))
    else $error("strobe fell without cause");
  fv_rise_a: assert property ($rose(frame_valid) |-> $past(frame_start)
    || $past(row_start)) else $error("frame strobe rose off a row start");
  dark_rise_a: assert property ($rose(dark_row_rd) |-> $past(frame_start)
    && $past(dark_row_enable)) else $error("dark row began off frame start");
  xenon_apply_a: assert property ($changed(one_frame_int) |-> $past(frame_start, 2))
    else $error("xenon mode applied off frame start");
  lv_rise_a: assert property ($rose(line_valid) |-> $past(pix_tick))
    else $error("line strobe rose without a pixel");
  fifo_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("stalled output word changed");
  strobe_c: cover property ($rose(lamp_strobe));
  dark_c: cover property ($rose(dark_row_rd));
  stall_c: cover property (out_valid && !out_ready);
endmodule
bind drf_core drf_core_sva u_sva (.sys_clk, .rst_n, .reg_addr, .reg_rd, .reg_rdata,
  .frame_start, .row_start, .dark_row_enable, .reset_soon, .readout_done, .vblank, .pix_tick,
  .frame_valid, .line_valid, .out_valid, .out_ready, .out_data, .dark_row_rd, .hblank_min_add,
  .hblank_cut, .one_frame_int, .lamp_strobe);
`default_nettype wire

// [tb/drf_host_model.sv]
// Host camera controller taking the pixel stream
// Assumes sys_clk; the bench raises stall to hold back the drain side
`timescale 1ns/1ns
`default_nettype none
module drf_host_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Pixel drain
  input wire logic out_valid,
  output logic out_ready,
  input wire logic [9:0] out_data,
  // Test control
  input wire logic stall
);
  // ****************
  // Word capture
  // ****************
  logic [9:0] rx_q[$];
  always @(posedge sys_clk) begin
    if (rst_n && out_valid && out_ready) begin
      rx_q.push_back(out_data);
    end
    out_ready <= rst_n && !stall;
  end
endmodule
`default_nettype wire

// [tb/tb_drf_core.sv]
// Self-checking bench for the readout framing and strobe block
// Drives the register port and frame timing; host model drains pixels
`timescale 1ns/1ns
`default_nettype none
module tb_drf_core;
  logic sys_clk, rst_n, reg_wr, reg_rd, active_row, dark_row_enable, vblank;
  logic pix_tick, line_active, pix_ready, frame_valid, line_valid, out_valid, out_ready;
  logic dark_row_rd, dark_col_rd, one_frame_int, lamp_strobe, stall;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [4:0] evs;
  logic [9:0] pix_data, out_data;
  logic [2:0] dark_row_addr;
  logic [5:0] hblank_min_add, hblank_cut;
  logic [9:0] exp_q[$];
  int n_fail = 0;
  int total_checks = 0;
  int cycles = 0;
  localparam logic [4:0] FS = 5'h01, RS = 5'h02, RSOON = 5'h04, RDONE_R = 5'h08;
  localparam logic [4:0] RDONE = 5'h10;
  drf_core dut (.sys_clk, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
    .frame_start(evs[0]), .row_start(evs[1]), .active_row, .dark_row_enable,
    .reset_soon(evs[2]), .reset_done(evs[3]), .readout_done(evs[4]), .vblank, .pix_tick,
    .line_active, .pix_data, .pix_ready, .frame_valid, .line_valid, .out_valid, .out_ready,
    .out_data, .dark_row_rd, .dark_row_addr, .dark_col_rd, .hblank_min_add, .hblank_cut,
    .one_frame_int, .lamp_strobe);
  drf_host_model host (.sys_clk, .rst_n, .out_valid, .out_ready, .out_data, .stall);
  // ****************
  // Tasks
  // ****************
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", w, e, g);
    end
  endtask
  task automatic pulse(input logic [4:0] m);
    @(posedge sys_clk);
    evs <= m;
    @(posedge sys_clk);
    evs <= 5'h00;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk("reg_rdata", e, reg_rdata);
  endtask
  task automatic tick(input logic [9:0] d, input logic la);
    @(posedge sys_clk);
    pix_tick <= 1'b1;
    pix_data <= d;
    line_active <= la;
    @(posedge sys_clk);
    pix_tick <= 1'b0;
    @(posedge sys_clk);
    #1;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 6000) begin
      n_fail++;
      give_verdict();
    end
  end
  // ****************
  // Tests
  // ****************
  initial begin
    {rst_n, reg_wr, reg_rd, dark_row_enable, vblank, pix_tick, line_active, stall} = '0;
    {reg_addr, reg_wdata, evs, pix_data} = '0;
    active_row = 1'b1;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd_chk(8'h22, 16'h000F);
    rd_chk(8'h23, 16'h0200);
    rd_chk(8'h24, 16'h0000);
    wr(8'h22, 16'hFFFF);
    rd_chk(8'h22, 16'h03FF);
    chk("hblank_cut", 16'h0016, 16'(hblank_cut));
    wr(8'h22, 16'h0100);
    repeat (2) @(posedge sys_clk);
    #1;
    chk("hblank_min_add", 16'h0016, 16'(hblank_min_add));
    chk("hblank_cut", 16'h0000, 16'(hblank_cut));
    wr(8'h23, 16'hFFFF);
    rd_chk(8'h23, 16'h3FFF);
    wr(8'h23, 16'h0200);
    $display("test registers done");
    wr(8'h22, 16'h00A1);
    dark_row_enable <= 1'b1;
    pulse(FS);
    chk("frame_valid", 1, frame_valid);
    chk("dark_row_rd", 1, dark_row_rd);
    chk("dark_row_addr", 2, 16'(dark_row_addr));
    pulse(RS);
    chk("dark_row_addr", 3, 16'(dark_row_addr));
    pulse(RS);
    chk("dark_row_rd", 0, dark_row_rd);
    chk("frame_valid", 1, frame_valid);
    $display("test dark rows done");
    wr(8'h22, 16'h0300);
    dark_row_enable <= 1'b0;
    stall <= 1'b1;
    pulse(FS);
    pulse(RS);
    for (int i = 0; i < 64 && pix_ready === 1'b1; i++) begin
      tick(10'(i), i >= 24);
      if (i == 1 || i == 2) chk("line_valid", 16'(i == 2), line_valid);
      if (i == 10 || i == 30) chk("dark_col_rd", 16'(i == 10), dark_col_rd);
      if (i >= 2) exp_q.push_back(i < 22 ? 10'(i) : (i < 24 ? 10'h000 : 10'(i)));
    end
    chk("pix_ready", 0, pix_ready);
    @(posedge sys_clk);
    stall <= 1'b0;
    for (int j = 0; j < 200 && host.rx_q.size() < exp_q.size(); j++) @(posedge sys_clk);
    repeat (4) @(posedge sys_clk);
    #1;
    chk("rx_count", 16'(exp_q.size()), 16'(host.rx_q.size()));
    foreach (exp_q[k]) chk("out_data", 16'(exp_q[k]), 16'(host.rx_q[k]));
    chk("out_valid", 0, out_valid);
    $display("test dark columns done");
    wr(8'h23, 16'h0300);
    pulse(RSOON);
    chk("lamp_strobe", 0, lamp_strobe);
    for (int f = 0; f < 4; f++) begin
      if (f == 2) wr(8'h23, 16'h0100);
      pulse(FS);
      pulse(RSOON);
      chk("lamp_strobe", 16'(f < 3), lamp_strobe);
      if (f == 0) rd_chk(8'h23, 16'hC300);
      pulse(RDONE);
      chk("lamp_strobe", 0, lamp_strobe);
    end
    pulse(FS);
    rd_chk(8'h23, 16'h0100);
    $display("test lamp strobe done");
    wr(8'h23, 16'h0000);
    pulse(FS);
    wr(8'h23, 16'h2603);
    pulse(FS);
    chk("one_frame_int", 1, one_frame_int);
    pulse(RDONE_R);
    vblank <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    chk("lamp_strobe", 1, lamp_strobe);
    for (int k = 1; k <= 3; k++) begin
      pulse(RS);
      chk("lamp_strobe", 16'(k < 3), lamp_strobe);
    end
    vblank <= 1'b0;
    wr(8'h23, 16'h2600);
    pulse(FS);
    pulse(RDONE_R);
    vblank <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    chk("lamp_strobe", 0, lamp_strobe);
    @(posedge sys_clk);
    vblank <= 1'b0;
    wr(8'h23, 16'h2202);
    pulse(FS);
    pulse(RDONE_R);
    vblank <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    chk("lamp_strobe", 0, lamp_strobe);
    vblank <= 1'b0;
    pulse(RDONE);
    vblank <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    chk("lamp_strobe", 1, lamp_strobe);
    vblank <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    chk("lamp_strobe", 0, lamp_strobe);
    $display("test xenon strobe done");
    give_verdict();
  end
endmodule
`default_nettype wire
